// ===== src/mcs_pkg.sv
// Package for the general control, sleep and external interrupt block.
// Assumes a single core clock and a 32-bit classic Wishbone register bus.
`default_nettype none

package mcs_pkg;

  // ===========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] MCS_OFS_GENERAL_CONTROL = 8'h00;
  localparam logic [7:0] MCS_OFS_EXT_IRQ_MASK    = 8'h04;
  localparam logic [7:0] MCS_OFS_STATUS          = 8'h08;

  // ===========================================================================
  // General control field positions
  localparam int MCS_BIT_EXT_MEMORY_ENABLE     = 7;
  localparam int MCS_BIT_EXT_MEMORY_WAIT_STATE = 6;
  localparam int MCS_BIT_SLEEP_PERMIT          = 5;
  localparam int MCS_BIT_SLEEP_KIND_SELECT     = 4;
  localparam int MCS_BIT_LINE_B_SENSE_LO       = 2;
  localparam int MCS_BIT_LINE_A_SENSE_LO       = 0;

  // Mask register field positions
  localparam int MCS_BIT_MASK_LINE_B = 7;
  localparam int MCS_BIT_MASK_LINE_A = 6;

  // Values after reset
  localparam logic [7:0] MCS_RST_GENERAL_CONTROL = 8'h00;
  localparam logic [1:0] MCS_RST_MASK            = 2'h0;

  // ===========================================================================
  // Sense codes
  localparam logic [1:0] MCS_SENSE_LOW      = 2'h0;
  localparam logic [1:0] MCS_SENSE_RESERVED = 2'h1;
  localparam logic [1:0] MCS_SENSE_FALL     = 2'h2;
  localparam logic [1:0] MCS_SENSE_RISE     = 2'h3;

  // Cycles from request taken to done pulse, without and with wait state
  localparam int MCS_XM_CYCLES_NORMAL = 3;
  localparam int MCS_XM_CYCLES_WAIT   = 4;

  // ===========================================================================
  // State encodings
  typedef enum logic [1:0] {
    MCS_SL_RUN   = 2'b00,
    MCS_SL_IDLE  = 2'b01,
    MCS_SL_PDOWN = 2'b10
  } mcs_sleep_t;

  typedef enum logic [1:0] {
    MCS_XM_IDLE   = 2'b00,
    MCS_XM_ADDR   = 2'b01,
    MCS_XM_WAIT   = 2'b10,
    MCS_XM_STROBE = 2'b11
  } mcs_xm_t;

  // ===========================================================================
  // Complete state of the block
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  mask;      // [1] line B, [0] line A
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  prev;
    mcs_sleep_t  slp;
    logic        wake;
    mcs_xm_t     xm;
    logic [15:0] xm_addr;
    logic [7:0]  xm_wdata;
    logic        xm_we;
    logic [7:0]  xm_rdata;
    logic        xm_done;
    logic        ack;
    logic [31:0] dat;
  } mcs_state_t;

  localparam mcs_state_t MCS_STATE_RESET = '{
    ctrl: MCS_RST_GENERAL_CONTROL, mask: MCS_RST_MASK, sync1: 2'h3, sync2: 2'h3, prev: 2'h3,
    slp: MCS_SL_RUN, wake: 1'b0, xm: MCS_XM_IDLE, xm_addr: 16'h0000, xm_wdata: 8'h00,
    xm_we: 1'b0, xm_rdata: 8'h00, xm_done: 1'b0, ack: 1'b0, dat: 32'h0000_0000};

endpackage : mcs_pkg

`default_nettype wire

// ===== src/mcs_general_control.sv
// General control block: external memory port, sleep control, two external interrupt lines.
// Assumes pins are synchronous to clk_i except the interrupt pins, which are resynchronised here.
`default_nettype none

module mcs_general_control
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core side
  input  wire logic        sleep_instr_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        internal_irq_i,
  input  wire logic        wdt_enabled_i,
  input  wire logic        wdt_timeout_i,
  output logic             core_stop_o,
  output logic             osc_stop_o,
  output logic             wake_o,
  output logic             irq_line_a_o,
  output logic             irq_line_b_o,
  // External memory request from the core
  input  wire logic        xm_req_i,
  input  wire logic        xm_we_i,
  input  wire logic [15:0] xm_addr_i,
  input  wire logic [7:0]  xm_wdata_i,
  output logic      [7:0]  xm_rdata_o,
  output logic             xm_done_o,
  output logic             xm_busy_o,
  // External interrupt pins (read back from the pad even when driven)
  input  wire logic        ext_irq_line_a_i,
  input  wire logic        ext_irq_line_b_i,
  // Port settings from the ordinary port logic
  input  wire logic [7:0]  port_a_out_i,
  input  wire logic [7:0]  port_a_dir_i,
  input  wire logic [7:0]  port_c_out_i,
  input  wire logic [7:0]  port_c_dir_i,
  input  wire logic [1:0]  port_d_strobe_out_i,  // [1] write strobe pin, [0] read strobe pin
  input  wire logic [1:0]  port_d_strobe_dir_i,
  // Pads
  input  wire logic [7:0]  pa_i,
  output logic      [7:0]  pa_o,
  output logic      [7:0]  pa_oe_o,
  output logic      [7:0]  pc_o,
  output logic      [7:0]  pc_oe_o,
  output logic             wr_n_o,
  output logic             wr_oe_o,
  output logic             rd_n_o,
  output logic             rd_oe_o,
  output logic             ale_o
);

  // ===========================================================================
  // Helpers

  // Request decode for one line; the reserved code never requests
  function automatic logic sense_req(input logic [1:0] mode, input logic cur, input logic prv);
    case (mode)
      MCS_SENSE_LOW:  sense_req = ~cur;
      MCS_SENSE_FALL: sense_req = prv & ~cur;
      MCS_SENSE_RISE: sense_req = ~prv & cur;
      default:        sense_req = 1'b0;
    endcase
  endfunction : sense_req

  mcs_state_t st_reg;
  mcs_state_t st_next;

  logic [1:0] sense_a;
  logic [1:0] sense_b;
  logic       req_a;
  logic       req_b;
  logic       level_wake;
  logic       bus_go;
  logic       bus_write;
  logic       xm_on;

  // ===========================================================================
  // Interrupt requests

  // Pins are sampled after two flops, so a pin driven by the port still triggers
  always_comb begin
    sense_a    = st_reg.ctrl[MCS_BIT_LINE_A_SENSE_LO +: 2];
    sense_b    = st_reg.ctrl[MCS_BIT_LINE_B_SENSE_LO +: 2];
    req_a      = global_irq_en_i & st_reg.mask[0] & sense_req(sense_a, st_reg.sync2[0], st_reg.prev[0]);
    req_b      = global_irq_en_i & st_reg.mask[1] & sense_req(sense_b, st_reg.sync2[1], st_reg.prev[1]);
    // Only level sense survives a stopped oscillator, so of the line requests only it may end power-down
    level_wake = (req_a & (sense_a == MCS_SENSE_LOW)) | (req_b & (sense_b == MCS_SENSE_LOW));
  end

  assign irq_line_a_o = req_a;
  assign irq_line_b_o = req_b;

  // ===========================================================================
  // Next state

  assign xm_on     = st_reg.ctrl[MCS_BIT_EXT_MEMORY_ENABLE];
  assign bus_go    = wb_cyc_i & wb_stb_i;
  assign bus_write = bus_go & wb_we_i & st_reg.ack & wb_sel_i[0];

  always_comb begin
    st_next         = st_reg;
    st_next.wake    = 1'b0;
    st_next.xm_done = 1'b0;

    // Two-flop synchroniser, then one sample of history for edge detection
    st_next.sync1 = {ext_irq_line_b_i, ext_irq_line_a_i};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;

    // Bus: ack one cycle after the strobe, write lands on the acked edge
    st_next.ack = bus_go & ~st_reg.ack;
    if (bus_go && !st_reg.ack) begin
      case (wb_adr_i)
        MCS_OFS_GENERAL_CONTROL: st_next.dat = {24'h000000, st_reg.ctrl};
        MCS_OFS_EXT_IRQ_MASK:    st_next.dat = {24'h000000, st_reg.mask, 6'h00};
        MCS_OFS_STATUS:          st_next.dat = {27'h0000000, xm_busy_o, st_reg.sync2,
                                                st_reg.slp == MCS_SL_PDOWN, st_reg.slp == MCS_SL_IDLE};
        default:                 st_next.dat = 32'h0000_0000;
      endcase
    end
    if (bus_write) begin
      case (wb_adr_i)
        MCS_OFS_GENERAL_CONTROL: st_next.ctrl = wb_dat_i[7:0];
        MCS_OFS_EXT_IRQ_MASK:    st_next.mask = {wb_dat_i[MCS_BIT_MASK_LINE_B], wb_dat_i[MCS_BIT_MASK_LINE_A]};
        default:                 st_next.mask = st_reg.mask;  // Status and unmapped ignore writes
      endcase
    end

    // Sleep control; registers are never touched on wake-up
    case (st_reg.slp)
      MCS_SL_RUN: begin
        if (sleep_instr_i && st_reg.ctrl[MCS_BIT_SLEEP_PERMIT]) begin
          st_next.slp = st_reg.ctrl[MCS_BIT_SLEEP_KIND_SELECT] ? MCS_SL_PDOWN : MCS_SL_IDLE;
        end
      end
      MCS_SL_IDLE: begin
        if (req_a || req_b || internal_irq_i || wdt_timeout_i) begin
          st_next.slp  = MCS_SL_RUN;
          st_next.wake = 1'b1;
        end
      end
      MCS_SL_PDOWN: begin
        if (level_wake || (wdt_enabled_i && wdt_timeout_i)) begin
          st_next.slp  = MCS_SL_RUN;
          st_next.wake = 1'b1;
        end
      end
      default: st_next.slp = MCS_SL_RUN;
    endcase

    // External memory cycle: address phase, optional wait, strobe phase
    case (st_reg.xm)
      MCS_XM_IDLE: begin
        if (xm_req_i && xm_on) begin
          st_next.xm       = MCS_XM_ADDR;
          st_next.xm_addr  = xm_addr_i;
          st_next.xm_wdata = xm_wdata_i;
          st_next.xm_we    = xm_we_i;
        end
      end
      MCS_XM_ADDR: begin
        st_next.xm = st_reg.ctrl[MCS_BIT_EXT_MEMORY_WAIT_STATE] ? MCS_XM_WAIT : MCS_XM_STROBE;
      end
      MCS_XM_WAIT: begin
        st_next.xm = MCS_XM_STROBE;
      end
      MCS_XM_STROBE: begin
        st_next.xm       = MCS_XM_IDLE;
        st_next.xm_done  = 1'b1;
        st_next.xm_rdata = st_reg.xm_we ? st_reg.xm_rdata : pa_i;
      end
      default: st_next.xm = MCS_XM_IDLE;
    endcase
  end

  // A synchronous reset lands in RUN from any sleep state, which is the wake to the reset vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= MCS_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================================
  // Outputs

  assign wb_ack_o    = st_reg.ack;
  assign wb_dat_o    = st_reg.dat;
  assign core_stop_o = st_reg.slp != MCS_SL_RUN;
  assign osc_stop_o  = st_reg.slp == MCS_SL_PDOWN;
  assign wake_o      = st_reg.wake;
  assign xm_rdata_o  = st_reg.xm_rdata;
  assign xm_done_o   = st_reg.xm_done;
  assign xm_busy_o   = st_reg.xm != MCS_XM_IDLE;

  // Pin muxing; with the memory port on, direction settings are overridden
  always_comb begin
    if (xm_on) begin
      ale_o   = st_reg.xm == MCS_XM_ADDR;
      pc_o    = st_reg.xm_addr[15:8];
      pc_oe_o = 8'hFF;
      wr_oe_o = 1'b1;
      rd_oe_o = 1'b1;
      wr_n_o  = ~(st_reg.xm_we && (st_reg.xm == MCS_XM_WAIT || st_reg.xm == MCS_XM_STROBE));
      rd_n_o  = ~(!st_reg.xm_we && (st_reg.xm == MCS_XM_WAIT || st_reg.xm == MCS_XM_STROBE));
      // Bus turns around for reads after the address phase
      pa_o    = (st_reg.xm == MCS_XM_ADDR) ? st_reg.xm_addr[7:0] : st_reg.xm_wdata;
      pa_oe_o = (st_reg.xm == MCS_XM_ADDR || st_reg.xm_we) ? 8'hFF : 8'h00;
    end else begin
      ale_o   = 1'b0;
      pc_o    = port_c_out_i;
      pc_oe_o = port_c_dir_i;
      wr_n_o  = port_d_strobe_out_i[1];
      wr_oe_o = port_d_strobe_dir_i[1];
      rd_n_o  = port_d_strobe_out_i[0];
      rd_oe_o = port_d_strobe_dir_i[0];
      pa_o    = port_a_out_i;
      pa_oe_o = port_a_dir_i;
    end
  end

  // ===========================================================================
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence xm_start_s;
    st_reg.xm == MCS_XM_IDLE && xm_req_i && xm_on;
  endsequence

  sequence sleep_entry_s;
    st_reg.slp == MCS_SL_RUN && sleep_instr_i && st_reg.ctrl[MCS_BIT_SLEEP_PERMIT] && !bus_write;
  endsequence

  xm_pin_override_a: assert property (
    (xm_on && st_reg.xm == MCS_XM_ADDR) |-> (pa_oe_o == 8'hFF && pc_oe_o == 8'hFF && ale_o
      && pc_o == st_reg.xm_addr[15:8] && pa_o == st_reg.xm_addr[7:0]))
    else $error("external memory does not own the pins");

  port_passthru_a: assert property (
    !xm_on |-> (pa_o == port_a_out_i && pa_oe_o == port_a_dir_i && pc_oe_o == port_c_dir_i && !ale_o))
    else $error("ports do not follow their own settings");

  // A control write on the taken edge would change the wait bit that the address phase reads
  xm_normal_len_a: assert property (
    (xm_start_s ##0 (!st_reg.ctrl[MCS_BIT_EXT_MEMORY_WAIT_STATE] && !bus_write))
      |=> !xm_done_o [*2] ##1 xm_done_o)
    else $error("normal access not two cycles");

  xm_wait_len_a: assert property (
    (xm_start_s ##0 (st_reg.ctrl[MCS_BIT_EXT_MEMORY_WAIT_STATE] && !bus_write))
      |=> !xm_done_o [*3] ##1 xm_done_o)
    else $error("wait-state access not three cycles");

  sleep_refused_a: assert property (
    (st_reg.slp == MCS_SL_RUN && sleep_instr_i && !st_reg.ctrl[MCS_BIT_SLEEP_PERMIT]) |=> !core_stop_o)
    else $error("sleep entered without permit");

  sleep_kind_a: assert property (
    sleep_entry_s |=> (osc_stop_o == $past(st_reg.ctrl[MCS_BIT_SLEEP_KIND_SELECT]) && core_stop_o))
    else $error("wrong sleep kind entered");

  line_b_gate_a: assert property (
    irq_line_b_o |-> (global_irq_en_i && st_reg.mask[1]))
    else $error("line B requests while gated off");

  line_a_level_a: assert property (
    (global_irq_en_i && st_reg.mask[0] && sense_a == MCS_SENSE_LOW && !st_reg.sync2[0]) |-> irq_line_a_o)
    else $error("line A low level not requesting");

  pin_to_level_a: assert property (
    (!ext_irq_line_a_i ##1 !ext_irq_line_a_i) |=> !st_reg.sync2[0])
    else $error("line A pin level not seen after synchroniser");

  edge_one_cycle_a: assert property (
    (irq_line_b_o && sense_b == MCS_SENSE_FALL) ##1 (sense_b == MCS_SENSE_FALL) |-> !irq_line_b_o)
    else $error("edge request longer than one cycle");

  idle_wake_a: assert property (
    (st_reg.slp == MCS_SL_IDLE && (wdt_timeout_i || internal_irq_i)) |=> (!core_stop_o && wake_o))
    else $error("idle not woken by internal event");

  pdown_hold_a: assert property (
    (st_reg.slp == MCS_SL_PDOWN && !level_wake && !(wdt_enabled_i && wdt_timeout_i)) |=> osc_stop_o)
    else $error("power-down left without valid wake source");

endmodule : mcs_general_control

`default_nettype wire

// ===== tb/mcs_ext_partner.sv
// External data memory model on the multiplexed address/data port.
// Assumes active-low strobes and the low address byte latched while ale is high.
`default_nettype none
module mcs_ext_partner (
  // Clock
  input  wire logic       clk_i,
  // Pins from the block
  input  wire logic       ale_i,
  input  wire logic [7:0] ad_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  // Data back to the pad
  output logic      [7:0] ad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg [0:255];
  logic [7:0] lo_reg   = 8'h00;
  logic [7:0] last_reg = 8'h00;
  // ===========================================================================
  // Latch the low address, store on the write strobe
  always @(posedge clk_i) begin
    if (ale_i) lo_reg <= ad_i;
    if (!wr_n_i) mem_reg[lo_reg] <= ad_i;
    if (!rd_n_i) last_reg <= mem_reg[lo_reg];
  end
  // Released bus shows the inverse of the last data, so stale data cannot pass
  assign ad_o = !rd_n_i ? mem_reg[lo_reg] : ~last_reg;
endmodule : mcs_ext_partner
`default_nettype wire

// ===== tb/mcs_general_control_test.sv
// Self-checking bench for the general control block.
// Assumes the memory model mcs_ext_partner and a 50 MHz core clock.
`default_nettype none
module mcs_general_control_test
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00, pa_out = 8'h00, pa_dir = 8'h00, pc_out = 8'h00, pc_dir = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0]  sel = 4'h0;
  logic        slp = 1'b0, gie = 1'b0, iirq = 1'b0, wdt_en = 1'b0, wdt_to = 1'b0;
  logic        stop, osc, wake, irq_a, irq_b, req = 1'b0, xwe = 1'b0, done, busy;
  logic [15:0] xadr = 16'h0;
  logic [7:0]  xwd = 8'h00, xrd, pa_o, pa_oe, pc_o, pc_oe, mem_ad, pa_pad, d;
  logic        pin_a = 1'b1, pin_b = 1'b1, wr_n, wr_oe, rd_n, rd_oe, ale;
  logic [1:0]  pd_out = 2'h0, pd_dir = 2'h0;
  int          num_errors = 0, num_checks = 0, wakes = 0, n, at;
  // ===========================================================================
  // Clock, pad resolution and instances
  always #10 clk = ~clk;
  assign pa_pad = (pa_oe & pa_o) | (~pa_oe & mem_ad);
  always @(negedge clk) if (wake === 1'b1) wakes++;
  mcs_general_control dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_instr_i(slp),
    .global_irq_en_i(gie), .internal_irq_i(iirq), .wdt_enabled_i(wdt_en), .wdt_timeout_i(wdt_to),
    .core_stop_o(stop), .osc_stop_o(osc), .wake_o(wake), .irq_line_a_o(irq_a), .irq_line_b_o(irq_b),
    .xm_req_i(req), .xm_we_i(xwe), .xm_addr_i(xadr), .xm_wdata_i(xwd), .xm_rdata_o(xrd),
    .xm_done_o(done), .xm_busy_o(busy), .ext_irq_line_a_i(pin_a), .ext_irq_line_b_i(pin_b),
    .port_a_out_i(pa_out), .port_a_dir_i(pa_dir), .port_c_out_i(pc_out), .port_c_dir_i(pc_dir),
    .port_d_strobe_out_i(pd_out), .port_d_strobe_dir_i(pd_dir), .pa_i(pa_pad), .pa_o(pa_o),
    .pa_oe_o(pa_oe), .pc_o(pc_o), .pc_oe_o(pc_oe), .wr_n_o(wr_n), .wr_oe_o(wr_oe), .rd_n_o(rd_n),
    .rd_oe_o(rd_oe), .ale_o(ale));
  mcs_ext_partner mem (.clk_i(clk), .ale_i(ale), .ad_i(pa_pad), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_o(mem_ad));
  // ===========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, v};
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    d = rdat[7:0];
    chk("bus acknowledge", 32'd1, {31'd0, ack});
    chk("read upper bits", 24'h0, rdat[31:8]);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(what, exp, d);
  endtask : rd
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: slp <= 1'b1;
      1: iirq <= 1'b1;
      default: wdt_to <= 1'b1;
    endcase
    @(posedge clk);
    slp <= 1'b0;
    iirq <= 1'b0;
    wdt_to <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse
  // Drive a pin level, count request cycles over six cycles
  task automatic wave(input int ln, input logic lvl, output int cnt, output int last);
    @(posedge clk);
    if (ln == 1) pin_b <= lvl;
    else pin_a <= lvl;
    cnt = 0;
    repeat (6) begin
      @(negedge clk);
      last = (ln == 1) ? int'(irq_b === 1'b1) : int'(irq_a === 1'b1);
      cnt += last;
    end
  endtask : wave
  // Memory cycle: count edges from the request to done
  task automatic xm(input logic w, input logic [15:0] a, input logic [7:0] v, input int exp_n);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1'b1;
    xwe <= w;
    xadr <= a;
    xwd <= v;
    do begin
      @(posedge clk);
      req <= 1'b0;
      k++;
      @(negedge clk);
      if (k == 1 && exp_n < 12) chk("address phase", {2'b11, a}, {busy, ale, pc_o, pa_o});
    end while (done !== 1'b1 && k < 12);
    chk("memory cycle length", exp_n, k);
  endtask : xm
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // ===========================================================================
  // Scenarios
  task automatic t_regs();
    rd("control reset", MCS_OFS_GENERAL_CONTROL, MCS_RST_GENERAL_CONTROL);
    rd("mask reset", MCS_OFS_EXT_IRQ_MASK, 8'h00);
    wb(1'b1, 8'h10, 8'hFF, 4'h1);
    rd("unmapped", 8'h10, 8'h00);
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h3C, 4'h0);
    rd("dropped write", MCS_OFS_GENERAL_CONTROL, 8'h00);
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h3C, 4'h1);
    rd("control rw", MCS_OFS_GENERAL_CONTROL, 8'h3C);
    $display("test registers done");
  endtask : t_regs
  task automatic t_mem();
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h00, 4'h1);
    @(posedge clk);
    {pa_out, pa_dir, pc_out, pc_dir, pd_out, pd_dir} <= {32'h5AC3_A53C, 4'h9};
    @(negedge clk);
    chk("port pins", {32'h5AC3_A53C, 4'h9}, {pa_o, pa_oe, pc_o, pc_oe, wr_n, rd_n, wr_oe, rd_oe});
    xm(1'b1, 16'h1234, 8'h66, 12);
    for (int ws = 0; ws < 2; ws++) begin
      wb(1'b1, MCS_OFS_GENERAL_CONTROL, {1'b1, ws[0], 6'h0}, 4'h1);
      @(negedge clk);
      chk("strobes taken", 5'h1F, {pc_oe == 8'hFF, wr_n, rd_n, wr_oe, rd_oe});
      xm(1'b1, 16'hC35A + 16'(ws), 8'hA5 ^ 8'(ws), MCS_XM_CYCLES_NORMAL + ws);
      xm(1'b0, 16'hC35A + 16'(ws), 8'h00, MCS_XM_CYCLES_NORMAL + ws);
      chk("read data", 8'hA5 ^ 8'(ws), xrd);
    end
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h00, 4'h1);
    $display("test memory port done");
  endtask : t_mem
  task automatic t_irq(input int ln);
    int lo, hi, last;
    gie <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, MCS_OFS_EXT_IRQ_MASK, 8'h00, 4'h1);
      wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'(c) << (ln == 1 ? MCS_BIT_LINE_B_SENSE_LO : 0), 4'h1);
      wb(1'b1, MCS_OFS_EXT_IRQ_MASK, ln == 1 ? 8'h80 : 8'h40, 4'h1);
      wave(ln, 1'b0, lo, last);
      wave(ln, 1'b1, hi, at);
      if (c == 0) chk("level request", 2'h2, {last[0], at[0]});
      else chk("edge pulses", c == 1 ? 8'h00 : c == 2 ? 8'h10 : 8'h01, {lo[3:0], hi[3:0]});
    end
    wb(1'b1, MCS_OFS_EXT_IRQ_MASK, 8'h00, 4'h1);
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h00, 4'h1);
    wb(1'b1, MCS_OFS_EXT_IRQ_MASK, ln == 1 ? 8'h80 : 8'h40, 4'h1);
    rd("mask rw", MCS_OFS_EXT_IRQ_MASK, ln == 1 ? 8'h80 : 8'h40);
    gie <= 1'b0;
    wave(ln, 1'b0, lo, last);
    chk("gated request", 0, lo);
    wave(ln, 1'b1, hi, last);
    wb(1'b1, MCS_OFS_EXT_IRQ_MASK, 8'h00, 4'h1);
    $display("test line %0d done", ln);
  endtask : t_irq
  task automatic t_sleep();
    pulse(0);
    chk("no permit", 0, stop);
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h20, 4'h1);
    pulse(0);
    chk("idle entry", 2'h2, {stop, osc});
    rd("status idle", MCS_OFS_STATUS, 8'h0D);
    pulse(1);
    chk("idle wake", 32'd1, {stop, osc, wakes[29:0]});
    wb(1'b1, MCS_OFS_GENERAL_CONTROL, 8'h30, 4'h1);
    pulse(0);
    pulse(1);
    pulse(2);
    chk("power-down held", 2'h3, {stop, osc});
    @(posedge clk);
    wdt_en <= 1'b1;
    pulse(2);
    chk("watchdog wake", 32'd2, {stop, wakes[30:0]});
    wb(1'b1, MCS_OFS_EXT_IRQ_MASK, 8'h40, 4'h1);
    gie <= 1'b1;
    pulse(0);
    wave(0, 1'b0, n, at);
    chk("level wake", 32'd3, {stop, wakes[30:0]});
    wave(0, 1'b1, n, at);
    rd("state kept", MCS_OFS_GENERAL_CONTROL, 8'h30);
    pulse(0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset wake", 2'h0, {stop, osc});
    $display("test sleep done");
  endtask : t_sleep
  // ===========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_mem();
    t_irq(0);
    t_irq(1);
    t_sleep();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : mcs_general_control_test
`default_nettype wire
